//--- design/dcd_pkg.sv
// constants and types shared by the channel divider block
package dcd_pkg;

  // ****************************************
  // register indices and byte addresses
  // ****************************************
  localparam int unsigned   ADDR_W     = 12;
  localparam int unsigned   IDX_CNT0   = 'h190;
  localparam int unsigned   IDX_CTRL0  = 'h191;
  localparam int unsigned   IDX_ROUTE0 = 'h192;
  localparam int unsigned   IDX_CNT1   = 'h196;
  localparam int unsigned   IDX_CTRL1  = 'h197;
  localparam int unsigned   IDX_ROUTE1 = 'h198;
  localparam int unsigned   IDX_STATUS = 'h19F;
  localparam logic [11:0]   ADDR_CNT0   = 12'(4 * IDX_CNT0);
  localparam logic [11:0]   ADDR_CTRL0  = 12'(4 * IDX_CTRL0);
  localparam logic [11:0]   ADDR_ROUTE0 = 12'(4 * IDX_ROUTE0);
  localparam logic [11:0]   ADDR_CNT1   = 12'(4 * IDX_CNT1);
  localparam logic [11:0]   ADDR_CTRL1  = 12'(4 * IDX_CTRL1);
  localparam logic [11:0]   ADDR_ROUTE1 = 12'(4 * IDX_ROUTE1);
  localparam logic [11:0]   ADDR_STATUS = 12'(4 * IDX_STATUS);

  // ****************************************
  // reset values and field positions
  // ****************************************
  localparam logic [7:0]    RST_CNT    = 8'h00;
  localparam logic [7:0]    RST_CTRL0  = 8'h80;
  localparam logic [7:0]    RST_CTRL1  = 8'h00;
  localparam logic [1:0]    RST_ROUTE  = 2'h0;
  localparam int unsigned   BIT_BYPASS = 7;
  localparam int unsigned   BIT_NOSYNC = 6;
  localparam int unsigned   BIT_FORCE  = 5;
  localparam int unsigned   BIT_START  = 4;
  localparam int unsigned   BIT_DIRECT = 1;
  localparam int unsigned   BIT_DUTY_CORRECTION_DISABLE = 0;
  localparam logic [1:0]    SRC_OSC    = 2'h2;
  localparam logic [1:0]    SRC_EXT    = 2'h0;

  // one divider's settings, gathered from its registers
  typedef struct packed {
    logic [3:0] lowCnt;
    logic [3:0] highCnt;
    logic       bypass;
    logic       ignoreSync;
    logic       forceHigh;
    logic       startHigh;
    logic [3:0] phase;
    logic       dccDisable;
  } dcd_div_cfg_t;

  typedef enum logic {ST_OFFSET, ST_RUN} dcd_div_state_t;

endpackage

//--- design/dcd_divider.sv
// one programmable channel divider with offset, sync, force and duty correction
`timescale 1ns/1ns
`default_nettype none

module dcd_divider
  import dcd_pkg::*;
(
  input  wire logic         ref_clk,  // system clock
  input  wire logic         reset,    // sync reset, high
  input  wire dcd_div_cfg_t cfg,      // divider settings
  input  wire logic         distClk,  // divider input level
  input  wire logic         syncReq,  // chip-wide sync, high
  output var  logic         divOut,   // divider output
  output var  logic         running   // dividing, not waiting
);

  // ****************************************
  // phase lengths
  // ****************************************
  logic           distPrev_q;
  logic           inEdge;
  logic           holdSync;
  logic           forceNow;
  logic           override;
  logic [5:0]     total;
  logic [4:0]     hiLen;
  logic [4:0]     loLen;
  logic [3:0]     cnt_q;
  dcd_div_state_t state_q;

  // rising input edge marks one input cycle
  assign inEdge   = distClk & ~distPrev_q;
  assign holdSync = syncReq & ~cfg.ignoreSync;
  // ignoring sync applies the force level, so sync never reaches the output
  assign forceNow = cfg.ignoreSync;
  assign override = cfg.bypass | forceNow | holdSync;
  assign running  = (state_q == ST_RUN);

  // period is the sum of both phases; correction only splits it in half, the low phase taking any odd cycle
  always_comb begin
    total = 6'(cfg.highCnt) + 6'(cfg.lowCnt) + 6'h02;
    if (cfg.dccDisable) begin
      hiLen = 5'(cfg.highCnt) + 5'h01;
      loLen = 5'(cfg.lowCnt) + 5'h01;
    end else begin
      hiLen = total[5:1];
      loLen = 5'(total - 6'(total[5:1]));
    end
  end

  // input edge detector
  always_ff @(posedge ref_clk) begin
    distPrev_q <= reset ? 1'b0 : distClk;
  end

  // ****************************************
  // counting and output
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q <= ST_OFFSET;
      cnt_q   <= 4'h0;
      divOut  <= 1'b0;
    end else if (cfg.bypass) begin
      divOut  <= distClk;
      state_q <= ST_OFFSET;
      cnt_q   <= cfg.phase;
    end else if (forceNow) begin
      divOut  <= cfg.forceHigh;
      state_q <= ST_OFFSET;
      cnt_q   <= cfg.phase;
    end else if (holdSync) begin
      divOut  <= cfg.startHigh;
      state_q <= ST_OFFSET;
      cnt_q   <= cfg.phase;
    end else if (state_q == ST_OFFSET) begin
      divOut <= cfg.startHigh;
      if (inEdge && cnt_q == 4'h0) begin
        state_q <= ST_RUN;
        cnt_q   <= cfg.startHigh ? 4'(hiLen - 5'h01) : 4'(loLen - 5'h01);
      end else if (inEdge) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end else if (inEdge) begin
      if (cnt_q == 4'h0) begin
        divOut <= ~divOut;
        cnt_q  <= divOut ? 4'(loLen - 5'h01) : 4'(hiLen - 5'h01);
      end else begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_bypass_follow: assert property (@(posedge ref_clk) disable iff (reset)
    cfg.bypass |=> divOut == $past(distClk))
    else $error("bypass output does not follow input");
  a_force_level: assert property (@(posedge ref_clk) disable iff (reset)
    (forceNow && !cfg.bypass) |=> divOut == $past(cfg.forceHigh))
    else $error("forced level wrong");
  a_sync_hold: assert property (@(posedge ref_clk) disable iff (reset)
    (holdSync && !cfg.bypass) |=> (divOut == $past(cfg.startHigh) && !running))
    else $error("sync does not hold divider");
  a_offset_start: assert property (@(posedge ref_clk) disable iff (reset)
    (!override && !running && inEdge && cnt_q == 4'h0)
    |=> (running && divOut == $past(cfg.startHigh)))
    else $error("divider start level wrong");
  a_phase_switch: assert property (@(posedge ref_clk) disable iff (reset)
    (!override && running && inEdge && cnt_q == 4'h0) |=> divOut != $past(divOut))
    else $error("phase did not end on count");
  a_phase_hold: assert property (@(posedge ref_clk) disable iff (reset)
    (!override && running && !(inEdge && cnt_q == 4'h0)) |=> $stable(divOut))
    else $error("output changed mid phase");
  a_high_load: assert property (@(posedge ref_clk) disable iff (reset)
    (!override && running && inEdge && cnt_q == 4'h0 && !divOut)
    |=> cnt_q == 4'($past(hiLen) - 5'h01))
    else $error("high length loaded wrong");

endmodule // dcd_divider

`default_nettype wire

//--- design/dcd_channel_dividers.sv
// two channel dividers with output routing and an APB register file
//
// Added by the designer: the APB register port.
`timescale 1ns/1ns
`default_nettype none

module dcd_channel_dividers
  import dcd_pkg::*;
(
  input  wire logic        ref_clk,        // system clock
  input  wire logic        reset,          // sync reset, high
  input  wire logic        psel,           // apb select
  input  wire logic        penable,        // apb access phase
  input  wire logic        pwrite,         // apb write
  input  wire logic [11:0] paddr,          // apb byte address
  input  wire logic [31:0] pwdata,         // apb write data
  input  wire logic [3:0]  pstrb,          // apb byte strobes
  output var  logic        pready,         // apb ready
  output var  logic [31:0] prdata,         // apb read data
  output var  logic        pslverr,        // apb error
  input  wire logic        distClk,        // distribution clock level
  input  wire logic        oscIn,          // oscillator level
  input  wire logic        extClkIn,       // external clock level
  input  wire logic [1:0]  distSourceSel,  // distribution source select
  input  wire logic        syncReq,        // chip-wide sync, high
  output var  logic        firstPairOutA,  // first pair, output a
  output var  logic        firstPairOutB,  // first pair, output b
  output var  logic        secondPairOutA, // second pair, output a
  output var  logic        secondPairOutB  // second pair, output b
);

  // ****************************************
  // declarations
  // ****************************************
  logic [7:0]   cnt0_q;
  logic [7:0]   ctrl0_q;
  logic [1:0]   route0_q;
  logic [7:0]   cnt1_q;
  logic [7:0]   ctrl1_q;
  logic [1:0]   route1_q;
  logic [7:0]   rdData;
  logic         mapped;
  logic         setup;
  logic         wrEn;
  logic         div0Out;
  logic         div1Out;
  logic         div0Run;
  logic         div1Run;
  logic         pair0_q;
  logic         pair1_q;
  dcd_div_cfg_t cfg0;
  dcd_div_cfg_t cfg1;

  // ****************************************
  // apb slave handshake
  // ****************************************

  // setup phase starts a transfer
  assign setup = psel & ~penable;

  // write lands at the completing access edge only
  assign wrEn = psel & penable & pready & pwrite & mapped & pstrb[0];

  // ready answers the first access cycle, no waits
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  // read data captured in setup, held through access
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      prdata <= {24'h00_0000, rdData};
    end
  end

  // unmapped address answers with an error
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup & ~mapped;
    end
  end

  // ****************************************
  // address decode and read mux
  // ****************************************

  // narrow registers read in the low bits, rest zero
  always_comb begin
    mapped = 1'b1;
    rdData = 8'h00;
    if (paddr == ADDR_CNT0) begin
      rdData = cnt0_q;
    end else if (paddr == ADDR_CTRL0) begin
      rdData = ctrl0_q;
    end else if (paddr == ADDR_ROUTE0) begin
      rdData = {6'h00, route0_q};
    end else if (paddr == ADDR_CNT1) begin
      rdData = cnt1_q;
    end else if (paddr == ADDR_CTRL1) begin
      rdData = ctrl1_q;
    end else if (paddr == ADDR_ROUTE1) begin
      rdData = {6'h00, route1_q};
    end else if (paddr == ADDR_STATUS) begin
      rdData = {2'h0, div1Run, div0Run, pair1_q, pair0_q, div1Out, div0Out};
    end else begin
      mapped = 1'b0;
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************

  // first divider cycle counts
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cnt0_q <= RST_CNT;
    end else if (wrEn && paddr == ADDR_CNT0) begin
      cnt0_q <= pwdata[7:0];
    end
  end

  // first divider control, bypassed out of reset
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl0_q <= RST_CTRL0;
    end else if (wrEn && paddr == ADDR_CTRL0) begin
      ctrl0_q <= pwdata[7:0];
    end
  end

  // first channel routing and duty correction
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      route0_q <= RST_ROUTE;
    end else if (wrEn && paddr == ADDR_ROUTE0) begin
      route0_q <= pwdata[1:0];
    end
  end

  // second divider cycle counts
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cnt1_q <= RST_CNT;
    end else if (wrEn && paddr == ADDR_CNT1) begin
      cnt1_q <= pwdata[7:0];
    end
  end

  // second divider control, dividing out of reset
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl1_q <= RST_CTRL1;
    end else if (wrEn && paddr == ADDR_CTRL1) begin
      ctrl1_q <= pwdata[7:0];
    end
  end

  // second channel routing and duty correction
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      route1_q <= RST_ROUTE;
    end else if (wrEn && paddr == ADDR_ROUTE1) begin
      route1_q <= pwdata[1:0];
    end
  end

  // ****************************************
  // divider settings
  // ****************************************

  // first divider fields
  always_comb begin
    cfg0.lowCnt     = cnt0_q[7:4];
    cfg0.highCnt    = cnt0_q[3:0];
    cfg0.bypass     = ctrl0_q[BIT_BYPASS];
    cfg0.ignoreSync = ctrl0_q[BIT_NOSYNC];
    cfg0.forceHigh  = ctrl0_q[BIT_FORCE];
    cfg0.startHigh  = ctrl0_q[BIT_START];
    cfg0.phase      = ctrl0_q[3:0];
    cfg0.dccDisable = route0_q[BIT_DUTY_CORRECTION_DISABLE];
  end

  // second divider fields
  always_comb begin
    cfg1.lowCnt     = cnt1_q[7:4];
    cfg1.highCnt    = cnt1_q[3:0];
    cfg1.bypass     = ctrl1_q[BIT_BYPASS];
    cfg1.ignoreSync = ctrl1_q[BIT_NOSYNC];
    cfg1.forceHigh  = ctrl1_q[BIT_FORCE];
    cfg1.startHigh  = ctrl1_q[BIT_START];
    cfg1.phase      = ctrl1_q[3:0];
    cfg1.dccDisable = route1_q[BIT_DUTY_CORRECTION_DISABLE];
  end

  // ****************************************
  // dividers
  // ****************************************

  // first channel divider
  dcd_divider u_div0 (
    .ref_clk (ref_clk),
    .reset   (reset),
    .cfg     (cfg0),
    .distClk (distClk),
    .syncReq (syncReq),
    .divOut  (div0Out),
    .running (div0Run)
  );

  // second channel divider
  dcd_divider u_div1 (
    .ref_clk (ref_clk),
    .reset   (reset),
    .cfg     (cfg1),
    .distClk (distClk),
    .syncReq (syncReq),
    .divOut  (div1Out),
    .running (div1Run)
  );

  // ****************************************
  // output pair routing
  // ****************************************

  // first pair: divider, or oscillator or external clock when direct
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pair0_q <= 1'b0;
    end else if (route0_q[BIT_DIRECT] && distSourceSel == SRC_OSC) begin
      pair0_q <= oscIn;
    end else if (route0_q[BIT_DIRECT] && distSourceSel == SRC_EXT) begin
      pair0_q <= extClkIn;
    end else begin
      pair0_q <= div0Out;
    end
  end

  // second pair routed the same way
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pair1_q <= 1'b0;
    end else if (route1_q[BIT_DIRECT] && distSourceSel == SRC_OSC) begin
      pair1_q <= oscIn;
    end else if (route1_q[BIT_DIRECT] && distSourceSel == SRC_EXT) begin
      pair1_q <= extClkIn;
    end else begin
      pair1_q <= div1Out;
    end
  end

  // both outputs of a pair share one flop
  assign firstPairOutA  = pair0_q;
  assign firstPairOutB  = pair0_q;
  assign secondPairOutA = pair1_q;
  assign secondPairOutB = pair1_q;

  // ****************************************
  // checks
  // ****************************************
  a_reset_bypass: assert property (@(posedge ref_clk) disable iff (reset)
    $fell(reset) |-> (ctrl0_q[BIT_BYPASS] && !ctrl1_q[BIT_BYPASS]))
    else $error("bypass reset values wrong");
  a_apb_ready: assert property (@(posedge ref_clk) disable iff (reset)
    (psel && !penable) |=> (pready ##1 !pready))
    else $error("ready not one cycle after setup");
  a_unmapped_err: assert property (@(posedge ref_clk) disable iff (reset)
    (psel && !penable && !mapped) |=> pslverr)
    else $error("unmapped access without error");
  a_route_div: assert property (@(posedge ref_clk) disable iff (reset)
    !route0_q[BIT_DIRECT] |=> firstPairOutA == $past(div0Out))
    else $error("first pair not fed by divider");
  a_route_osc: assert property (@(posedge ref_clk) disable iff (reset)
    (route0_q[BIT_DIRECT] && distSourceSel == SRC_OSC) |=> firstPairOutA == $past(oscIn))
    else $error("first pair not fed by oscillator");
  a_second_ext: assert property (@(posedge ref_clk) disable iff (reset)
    (route1_q[BIT_DIRECT] && distSourceSel == SRC_EXT) |=> secondPairOutB == $past(extClkIn))
    else $error("second pair not fed by external clock");
  a_second_osc: assert property (@(posedge ref_clk) disable iff (reset)
    (route1_q[BIT_DIRECT] && distSourceSel == SRC_OSC) |=> secondPairOutA == $past(oscIn))
    else $error("second pair not fed by oscillator");
  a_second_div: assert property (@(posedge ref_clk) disable iff (reset)
    !route1_q[BIT_DIRECT] |=> secondPairOutA == $past(div1Out))
    else $error("second pair not fed by divider");
  a_route_ext: assert property (@(posedge ref_clk) disable iff (reset)
    (route0_q[BIT_DIRECT] && distSourceSel == SRC_EXT) |=> firstPairOutB == $past(extClkIn))
    else $error("first pair not fed by external clock");
  a_route_keep: assert property (@(posedge ref_clk) disable iff (reset)
    (distSourceSel != SRC_OSC && distSourceSel != SRC_EXT) |=> firstPairOutA == $past(div0Out))
    else $error("other select moved first pair off divider");

  // register writes land only on a strobed access edge
  a_write_cnt0: assert property (@(posedge ref_clk) disable iff (reset)
    (psel && penable && pready && pwrite && pstrb[0] && paddr == ADDR_CNT0)
    |=> cnt0_q == $past(pwdata[7:0]))
    else $error("first count write lost");
  a_write_ctrl1: assert property (@(posedge ref_clk) disable iff (reset)
    (psel && penable && pready && pwrite && pstrb[0] && paddr == ADDR_CTRL1)
    |=> ctrl1_q == $past(pwdata[7:0]))
    else $error("second control write lost");
  a_write_route1: assert property (@(posedge ref_clk) disable iff (reset)
    (psel && penable && pready && pwrite && pstrb[0] && paddr == ADDR_ROUTE1)
    |=> route1_q == $past(pwdata[1:0]))
    else $error("second routing write lost");
  a_strobe_block: assert property (@(posedge ref_clk) disable iff (reset)
    (psel && penable && pready && pwrite && !pstrb[0])
    |=> ($stable(cnt0_q) && $stable(ctrl0_q) && $stable(cnt1_q) && $stable(ctrl1_q)))
    else $error("write without strobe landed");
  a_reset_regs: assert property (@(posedge ref_clk) disable iff (reset)
    $fell(reset) |-> (cnt0_q == RST_CNT && cnt1_q == RST_CNT && route0_q == RST_ROUTE
      && route1_q == RST_ROUTE))
    else $error("register reset values wrong");

  // answer shape on the bus
  a_err_ready: assert property (@(posedge ref_clk) disable iff (reset)
    pslverr |-> pready)
    else $error("error outside ready");
  a_read_upper: assert property (@(posedge ref_clk) disable iff (reset)
    pready |-> prdata[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");

endmodule // dcd_channel_dividers

`default_nettype wire

//--- testbench/differential_channel_divider_tb.sv
// self-checking bench for the two channel dividers and their register file
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, got, exp) begin total_checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("ERROR %s expected %0h seen %0h", nm, (exp), (got)); end end

module differential_channel_divider_tb
  import dcd_pkg::*;
;
  // ****************************************
  // signals
  // ****************************************
  logic        ref_clk       = 1'b0;
  logic        reset         = 1'b1;
  logic        psel          = 1'b0;
  logic        penable       = 1'b0;
  logic        pwrite        = 1'b0;
  logic [11:0] paddr         = 12'h000;
  logic [31:0] pwdata        = 32'h00000000;
  logic [3:0]  pstrb         = 4'hF;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        distClk       = 1'b0;
  logic        oscIn         = 1'b0;
  logic        extClkIn      = 1'b0;
  logic [1:0]  distSourceSel = 2'h0;
  logic        syncReq       = 1'b0;
  logic        firstPairOutA, firstPairOutB, secondPairOutA, secondPairOutB;
  integer      seed          = 32'h02DC5B79;
  int          n_mismatch    = 0;
  int          total_checks  = 0;
  int          cycleCnt      = 0;
  logic        distRand      = 1'b0;
  logic [2:0]  hist1         = 3'h0;  // {dist, osc, ext} one cycle back
  logic [2:0]  hist2         = 3'h0;  // same, two cycles back
  logic [32:0] noteQ[$];              // expected {pslverr, prdata}

  dcd_channel_dividers uut (
    .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .distClk(distClk), .oscIn(oscIn), .extClkIn(extClkIn),
    .distSourceSel(distSourceSel), .syncReq(syncReq), .firstPairOutA(firstPairOutA),
    .firstPairOutB(firstPairOutB), .secondPairOutA(secondPairOutA),
    .secondPairOutB(secondPairOutB)
  );

  // ****************************************
  // clock, stimulus sources, timeout
  // ****************************************
  always #5 ref_clk = ~ref_clk;

  // input clocks: divider input toggles or goes random, sources random
  always @(posedge ref_clk) begin
    distClk  <= distRand ? 1'($random(seed)) : ~distClk;
    oscIn    <= 1'($random(seed));
    extClkIn <= 1'($random(seed));
    hist1    <= {distClk, oscIn, extClkIn};
    hist2    <= hist1;
    cycleCnt <= cycleCnt + 1;
    if (cycleCnt == 20000) begin
      n_mismatch++;
      results();
    end
  end

  // monitor: bus answers against oldest note, pair legs against each other
  always @(posedge ref_clk) begin
    logic [32:0] note;
    if (psel && penable && pready === 1'b1) begin
      note = (noteQ.size() > 0) ? noteQ.pop_front() : 33'h1FFFFFFFF;
      `CHK("apb answer", {pslverr, pwrite ? 32'h0 : prdata}, note)
    end
    `CHK("pair b", {firstPairOutB, secondPairOutB}, {firstPairOutA, secondPairOutA})
  end

  // ****************************************
  // bus and measurement tasks
  // ****************************************
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] note);
    @(posedge ref_clk);
    noteQ.push_back(note);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // wait for the answer; only the bench timeout ends a hang
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d}, 33'h0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    apb(1'b0, a, 32'h0, e);
  endtask

  function automatic logic po(input logic s);
    return s ? secondPairOutA : firstPairOutA;
  endfunction

  // count edges until the chosen pair shows level v
  task automatic waitv(input logic s, input logic v, output int n);
    n = 0;
    while (po(s) !== v && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
  endtask

  task automatic meas(input logic s, input int hiExp, input int loExp);
    int n, hi, lo;
    waitv(s, 1'b0, n);
    waitv(s, 1'b1, n);
    waitv(s, 1'b0, hi);
    waitv(s, 1'b1, lo);
    `CHK("high width", hi, hiExp)
    `CHK("low width", lo, loExp)
  endtask

  // pair must copy one source, one or two cycles late
  task automatic follow(input logic s, input int idx, input logic late2);
    repeat (3) @(posedge ref_clk);
    repeat (12) begin
      @(posedge ref_clk);
      `CHK("pair level", po(s), late2 ? hist2[idx] : hist1[idx])
    end
  endtask

  task automatic hold(input logic s, input logic v);
    repeat (3) @(posedge ref_clk);
    repeat (10) begin
      @(posedge ref_clk);
      `CHK("held level", po(s), v)
    end
  endtask

  task automatic results();
    if (n_mismatch == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    int         p0, n;
    logic [7:0] c;
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    // reset values, refused accesses, strobe-less write
    rd(ADDR_CNT0, {1'b0, 24'h0, RST_CNT});
    rd(ADDR_CTRL0, {1'b0, 24'h0, RST_CTRL0});
    rd(ADDR_ROUTE0, 33'h0);
    rd(ADDR_CNT1, {1'b0, 24'h0, RST_CNT});
    rd(ADDR_CTRL1, {1'b0, 24'h0, RST_CTRL1});
    rd(ADDR_ROUTE1, 33'h0);
    rd(12'h641, {1'b1, 32'h0});
    apb(1'b1, 12'h004, 32'h000000FF, {1'b1, 32'h0});
    pstrb <= 4'h0;
    wr(ADDR_CNT1, 8'hA5);
    pstrb <= 4'hF;
    rd(ADDR_CNT1, 33'h0);
    // bypass and direct routing with random input levels
    distRand <= 1'b1;
    distSourceSel <= SRC_OSC;
    follow(1'b0, 2, 1'b1);
    wr(ADDR_CTRL1, 8'h80);
    follow(1'b1, 2, 1'b1);
    for (int s = 0; s < 2; s++) begin
      wr(s ? ADDR_ROUTE1 : ADDR_ROUTE0, 8'h02);
      for (int sel = 0; sel < 4; sel++) begin
        distSourceSel <= 2'(sel);
        follow(1'(s), sel == 2 ? 1 : (sel == 0 ? 0 : 2), sel[0]);
      end
      wr(s ? ADDR_ROUTE1 : ADDR_ROUTE0, 8'h01);
    end
    // counting with correction off, boundaries then random counts
    distRand <= 1'b0;
    wr(ADDR_CTRL0, 8'h00);
    wr(ADDR_CTRL1, 8'h00);
    for (int i = 0; i < 6; i++) begin
      c = (i < 2) ? 8'hFF : 8'($random(seed));
      if (i == 2) c = 8'h00;
      wr(i[0] ? ADDR_CNT1 : ADDR_CNT0, c);
      meas(i[0], 2 * (c[3:0] + 1), 2 * (c[7:4] + 1));
    end
    // correction on balances an odd total
    for (int s = 0; s < 2; s++) begin
      wr(s ? ADDR_ROUTE1 : ADDR_ROUTE0, 8'h00);
      wr(s ? ADDR_CNT1 : ADDR_CNT0, 8'h30);
      meas(1'(s), 4, 6);
    end
    // sync hold at start level, forcing with sync ignored
    syncReq <= 1'b1;
    wr(ADDR_CTRL0, 8'h10);
    hold(1'b0, 1'b1);
    wr(ADDR_CTRL0, 8'h00);
    hold(1'b0, 1'b0);
    wr(ADDR_CTRL0, 8'h70);
    hold(1'b0, 1'b1);
    wr(ADDR_CTRL0, 8'h50);
    hold(1'b0, 1'b0);
    wr(ADDR_CTRL1, 8'h10);
    hold(1'b1, 1'b1);
    // phase offset delays the first edge after sync release
    wr(ADDR_ROUTE0, 8'h01);
    wr(ADDR_CNT0, 8'h00);
    p0 = 0;
    for (int p = 0; p < 16; p += 5) begin
      wr(ADDR_CTRL0, 8'(p));
      repeat (4) @(posedge ref_clk);
      do @(posedge ref_clk); while (distClk !== 1'b0);
      syncReq <= 1'b0;
      waitv(1'b0, 1'b1, n);
      if (p == 0) p0 = n;
      else `CHK("offset delay", n, p0 + 2 * p)
      syncReq <= 1'b1;
      repeat (4) @(posedge ref_clk);
    end
    // sync ignored: force level stands with sync low as well
    syncReq <= 1'b0;
    wr(ADDR_CTRL0, 8'h60);
    hold(1'b0, 1'b1);
    wr(ADDR_CTRL0, 8'h40);
    hold(1'b0, 1'b0);
    results();
  end
endmodule // differential_channel_divider_tb

`default_nettype wire
